// ==== core/sync_serial_pkg.sv ====
// constants, register map and field layouts of the synchronous serial port
package sync_serial_pkg;

  // apb byte addresses of the register words
  localparam logic [11:0] addr_serial_control = 12'h000;
  localparam logic [11:0] addr_serial_shift_data = 12'h004;
  localparam logic [11:0] addr_xfer_irq = 12'h008;
  localparam logic [11:0] addr_baud_timer = 12'h00c;

  // serial_control field positions
  localparam int clock_select_lo_pos = 0;
  localparam int clock_select_hi_pos = 1;
  localparam int slave_select_pos = 2;
  localparam int transfer_busy_pos = 3;
  localparam int bit_count_pos = 4;
  localparam int unused_bit_pos = 7;

  // value after any reset: master, quarter time-base clock
  localparam logic [7:0] serial_control_reset = 8'h80;

  // xfer_irq word field positions
  localparam int irq_request_pos = 0;
  localparam int irq_enable_pos = 1;
  localparam int irq_prio_lo_pos = 2;
  localparam int irq_prio_hi_pos = 3;
  localparam int irq_vector_pos = 16;
  localparam logic [15:0] irq_vector = 16'h003e;

  // baud timer word field positions
  localparam int baud_reload_pos = 0;
  localparam int baud_run_pos = 8;
  localparam logic [7:0] baud_timer_last = 8'hff;

  // master shift clock choices and their half periods in time-base ticks
  typedef enum logic [1:0] {
    clk_tbc_div4 = 2'b00,
    clk_tbc_div16 = 2'b01,
    clk_tbc_div64 = 2'b10,
    clk_timer_half = 2'b11
  } clock_sel_t;
  localparam logic [4:0] half_ticks_div4 = 5'd2;
  localparam logic [4:0] half_ticks_div16 = 5'd8;
  localparam logic [4:0] half_ticks_div64 = 5'd31;

  localparam logic [2:0] last_bit_count = 3'd7;

  // control register as held in the block
  typedef struct packed {
    logic slave;
    clock_sel_t clk_sel;
  } serial_ctrl_t;

  // interrupt flags as held in the block
  typedef struct packed {
    logic request;
    logic enable;
    logic [1:0] prio;
  } irq_flags_t;

endpackage

// ==== core/sync_serial_port.sv ====
// eight-bit full-duplex clocked serial port with apb register access
//
// Summary of operation
// - writing the shift data register starts a full-duplex one-byte transfer
// - after eight bits the transfer ends and a completion request is raised
// - slave select sets clock pin direction: driven in master, input in slave
// - clock select bits pick the master shift clock; ignored in slave mode
// - any reset loads control 80h: master mode, quarter time-base clock
// - busy sets on a shift data write and clears when eight bits finish
// - control bits four to six show the live bit counter; busy, count read-only
// - control bit seven always reads one and ignores writes
// - in slave mode pulses after the eighth are ignored until a new write
// - output changes on shift clock falling edges, input sampled on rising edges
// - completion request is raised with the next instruction's first state
// - clock pin idles high; data output holds the last bit sent
// - a write during a transfer restarts shifting with the new byte
// - slave transfers complete on the external clock; request can end stop mode
// - completion sets a request flag gated by its own enable flag
// - four priority levels from two bits; vector address 003e
// - half timer overflow rate gives time-base over (256 minus reload), halved
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module sync_serial_port (
  input wire logic pclk, // apb clock, 40 mhz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic time_base_clock, // time-base clock from outside
  input wire logic first_instr_state, // cpu first instruction state strobe
  input wire logic shift_clock_pin_in, // clock pin level
  output logic shift_clock_pin_out, // clock pin driven value
  output logic shift_clock_pin_oe, // clock pin output enable
  input wire logic serial_in_pin, // serial data in
  output logic serial_out_pin, // serial data out
  output logic xfer_irq, // gated completion request, also stop wake
  output logic [1:0] xfer_irq_level // priority of the request
);

  // register state
  sync_serial_pkg::serial_ctrl_t ctrl_reg;
  sync_serial_pkg::irq_flags_t irq_reg;
  logic [7:0] shift_reg;
  logic busy_reg;
  logic [2:0] count_reg;
  logic sck_reg;
  logic done_pend_reg;
  logic [7:0] reload_reg;
  logic [7:0] timer_reg;
  logic timer_run_reg;
  logic timer_ovf_reg;
  logic [4:0] half_cnt_reg;

  // synchronisers for pin inputs
  logic tbc_s1_reg, tbc_s2_reg, tbc_s3_reg;
  logic sck_s1_reg, sck_s2_reg, sck_s3_reg;
  logic sin_s1_reg, sin_s2_reg;

  // decoded events
  logic wr_access, rd_access, mapped;
  logic wr_ctrl, wr_data, wr_irq, wr_timer;
  logic tbc_tick, half_done;
  logic fall_ev, rise_ev, xfer_done;
  logic [4:0] half_limit;

  // read mux, shared by the apb read path
  function automatic logic [31:0] read_word(input logic [11:0] a,
                                            input sync_serial_pkg::serial_ctrl_t c,
                                            input logic b, input logic [2:0] n,
                                            input logic [7:0] d,
                                            input sync_serial_pkg::irq_flags_t q,
                                            input logic [7:0] rl, input logic rn);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (a)
      sync_serial_pkg::addr_serial_control: begin
        w[sync_serial_pkg::unused_bit_pos] = 1'b1;
        w[sync_serial_pkg::bit_count_pos +: 3] = n;
        w[sync_serial_pkg::transfer_busy_pos] = b;
        w[sync_serial_pkg::slave_select_pos] = c.slave;
        w[sync_serial_pkg::clock_select_lo_pos +: 2] = c.clk_sel;
      end
      sync_serial_pkg::addr_serial_shift_data: begin
        w[7:0] = d;
      end
      sync_serial_pkg::addr_xfer_irq: begin
        w[sync_serial_pkg::irq_request_pos] = q.request;
        w[sync_serial_pkg::irq_enable_pos] = q.enable;
        w[sync_serial_pkg::irq_prio_lo_pos +: 2] = q.prio;
        w[sync_serial_pkg::irq_vector_pos +: 16] = sync_serial_pkg::irq_vector;
      end
      sync_serial_pkg::addr_baud_timer: begin
        w[sync_serial_pkg::baud_reload_pos +: 8] = rl;
        w[sync_serial_pkg::baud_run_pos] = rn;
      end
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // apb decode; a write lands on the completing access edge
  assign mapped = (paddr == sync_serial_pkg::addr_serial_control) ||
                  (paddr == sync_serial_pkg::addr_serial_shift_data) ||
                  (paddr == sync_serial_pkg::addr_xfer_irq) ||
                  (paddr == sync_serial_pkg::addr_baud_timer);
  assign wr_access = psel && penable && pready && pwrite && mapped;
  assign rd_access = psel && penable && !pready && !pwrite;
  assign wr_ctrl = wr_access && (paddr == sync_serial_pkg::addr_serial_control);
  assign wr_data = wr_access && (paddr == sync_serial_pkg::addr_serial_shift_data);
  assign wr_irq = wr_access && (paddr == sync_serial_pkg::addr_xfer_irq);
  assign wr_timer = wr_access && (paddr == sync_serial_pkg::addr_baud_timer);

  // apb answer: one wait state, read data and error registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      if (rd_access) begin
        prdata <= read_word(paddr, ctrl_reg, busy_reg, count_reg, shift_reg, irq_reg,
                            reload_reg, timer_run_reg);
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // two-flop synchronisers; the third tbc and sck flops only serve edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tbc_s1_reg <= 1'b0;
      tbc_s2_reg <= 1'b0;
      tbc_s3_reg <= 1'b0;
      sck_s1_reg <= 1'b1;
      sck_s2_reg <= 1'b1;
      sck_s3_reg <= 1'b1;
      sin_s1_reg <= 1'b0;
      sin_s2_reg <= 1'b0;
    end else begin
      tbc_s1_reg <= time_base_clock;
      tbc_s2_reg <= tbc_s1_reg;
      tbc_s3_reg <= tbc_s2_reg;
      sck_s1_reg <= shift_clock_pin_in;
      sck_s2_reg <= sck_s1_reg;
      sck_s3_reg <= sck_s2_reg;
      sin_s1_reg <= serial_in_pin;
      sin_s2_reg <= sin_s1_reg;
    end
  end

  assign tbc_tick = tbc_s2_reg && !tbc_s3_reg;

  // control register; busy, count and bit seven are not writable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.slave <= sync_serial_pkg::serial_control_reset[sync_serial_pkg::slave_select_pos];
      ctrl_reg.clk_sel <= sync_serial_pkg::clock_sel_t'(
        sync_serial_pkg::serial_control_reset[sync_serial_pkg::clock_select_lo_pos +: 2]);
    end else if (wr_ctrl) begin
      ctrl_reg.slave <= pwdata[sync_serial_pkg::slave_select_pos];
      ctrl_reg.clk_sel <= sync_serial_pkg::clock_sel_t'(pwdata[sync_serial_pkg::clock_select_lo_pos +: 2]);
    end
  end

  // baud timer: counts time-base ticks, reloads on overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_reg <= 8'h00;
      timer_reg <= 8'h00;
      timer_run_reg <= 1'b0;
      timer_ovf_reg <= 1'b0;
    end else begin
      timer_ovf_reg <= 1'b0;
      if (wr_timer) begin
        reload_reg <= pwdata[sync_serial_pkg::baud_reload_pos +: 8];
        timer_reg <= pwdata[sync_serial_pkg::baud_reload_pos +: 8];
        timer_run_reg <= pwdata[sync_serial_pkg::baud_run_pos];
      end else if (timer_run_reg && tbc_tick) begin
        if (timer_reg == sync_serial_pkg::baud_timer_last) begin
          timer_reg <= reload_reg; // period of 256 minus reload ticks
          timer_ovf_reg <= 1'b1;
        end else begin
          timer_reg <= timer_reg + 8'h01;
        end
      end
    end
  end

  // half period length of the master shift clock
  always_comb begin
    unique case (ctrl_reg.clk_sel)
      sync_serial_pkg::clk_tbc_div4: half_limit = sync_serial_pkg::half_ticks_div4;
      sync_serial_pkg::clk_tbc_div16: half_limit = sync_serial_pkg::half_ticks_div16;
      sync_serial_pkg::clk_tbc_div64: half_limit = sync_serial_pkg::half_ticks_div64;
      sync_serial_pkg::clk_timer_half: half_limit = sync_serial_pkg::half_ticks_div4;
    endcase
  end

  // one overflow per half period halves the overflow rate
  assign half_done = (ctrl_reg.clk_sel == sync_serial_pkg::clk_timer_half) ? timer_ovf_reg :
                     (tbc_tick && (half_cnt_reg == half_limit - 5'd1));

  // half period counter, restarted by each shift data write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt_reg <= 5'd0;
    end else if (wr_data || !busy_reg || half_done) begin
      half_cnt_reg <= 5'd0;
    end else if (tbc_tick) begin
      half_cnt_reg <= half_cnt_reg + 5'd1;
    end
  end

  // shift clock edges: own divider in master, synchronised pin in slave
  assign fall_ev = busy_reg && !wr_data && (ctrl_reg.slave ? (!sck_s2_reg && sck_s3_reg)
                                                           : (half_done && sck_reg));
  assign rise_ev = busy_reg && !wr_data && (ctrl_reg.slave ? (sck_s2_reg && !sck_s3_reg)
                                                           : (half_done && !sck_reg));
  assign xfer_done = rise_ev && (count_reg == sync_serial_pkg::last_bit_count);

  // master clock output, high at rest and driven only in master mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_reg <= 1'b1;
      shift_clock_pin_oe <= 1'b1;
    end else begin
      shift_clock_pin_oe <= !ctrl_reg.slave;
      if (wr_data || !busy_reg || ctrl_reg.slave) begin
        sck_reg <= 1'b1;
      end else if (half_done) begin
        sck_reg <= !sck_reg;
      end
    end
  end

  assign shift_clock_pin_out = sck_reg;

  // busy flag and bit counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      count_reg <= 3'd0;
    end else if (wr_data) begin
      busy_reg <= 1'b1;
      count_reg <= 3'd0;
    end else if (rise_ev) begin
      count_reg <= count_reg + 3'd1; // wraps after the eighth bit
      if (xfer_done) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // shift register: load on write, lsb out first, input enters at bit seven
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 8'h00;
      serial_out_pin <= 1'b0;
    end else if (wr_data) begin
      shift_reg <= pwdata[7:0]; // old byte discarded
    end else if (fall_ev) begin
      serial_out_pin <= shift_reg[0];
    end else if (rise_ev) begin
      shift_reg <= {sin_s2_reg, shift_reg[7:1]};
    end
  end

  // completion waits for the next instruction's first state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_pend_reg <= 1'b0;
    end else if (xfer_done) begin
      done_pend_reg <= 1'b1;
    end else if (first_instr_state) begin
      done_pend_reg <= 1'b0;
    end
  end

  // request, enable and priority flags; a new request beats a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= '0;
    end else begin
      if (done_pend_reg && first_instr_state) begin
        irq_reg.request <= 1'b1;
      end else if (wr_irq && !pwdata[sync_serial_pkg::irq_request_pos]) begin
        irq_reg.request <= 1'b0;
      end
      if (wr_irq) begin
        irq_reg.enable <= pwdata[sync_serial_pkg::irq_enable_pos];
        irq_reg.prio <= pwdata[sync_serial_pkg::irq_prio_lo_pos +: 2];
      end
    end
  end

  // gated request out; it also serves as the stop-mode wake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_irq <= 1'b0;
      xfer_irq_level <= 2'b00;
    end else begin
      xfer_irq <= irq_reg.request && irq_reg.enable;
      xfer_irq_level <= irq_reg.prio;
    end
  end

endmodule

// ==== dv/sync_serial_port_asserts.sv ====
// assertion checker for the synchronous serial port ports
`timescale 1ns/1ps
module sync_serial_port_asserts (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // direction
  input wire logic [11:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic time_base_clock, // time base
  input wire logic first_instr_state, // instruction strobe
  input wire logic shift_clock_pin_in, // clock pin level
  input wire logic shift_clock_pin_out, // clock pin drive
  input wire logic shift_clock_pin_oe, // clock pin enable
  input wire logic serial_in_pin, // data in
  input wire logic serial_out_pin, // data out
  input wire logic xfer_irq, // request
  input wire logic [1:0] xfer_irq_level // priority
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // finished reads of the control and interrupt words
  wire logic rd = psel && penable && pready && !pwrite;
  wire logic rd_ctl = rd && paddr == sync_serial_pkg::addr_serial_control;
  wire logic rd_irq = rd && paddr == sync_serial_pkg::addr_xfer_irq;
  property p_top_one; rd_ctl |-> prdata[7] && prdata[31:8] == 24'h000000; endproperty
  a_top_one: assert property (p_top_one) else $error("control bit seven not one");
  property p_idle_count; rd_ctl && !prdata[3] |-> prdata[6:4] == 3'h0; endproperty
  a_idle_count: assert property (p_idle_count) else $error("count not zero when idle");
  property p_reset_pins; $rose(presetn) |-> shift_clock_pin_out && shift_clock_pin_oe && !xfer_irq; endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins wrong after reset");
  property p_dir; rd_ctl |-> shift_clock_pin_oe == !prdata[2]; endproperty
  a_dir: assert property (p_dir) else $error("clock pin direction wrong");
  property p_idle_high; rd_ctl && !prdata[3] && !prdata[2] |-> shift_clock_pin_out; endproperty
  a_idle_high: assert property (p_idle_high) else $error("clock pin low when idle");
  property p_fall_out; shift_clock_pin_oe && $changed(serial_out_pin) |-> $fell(shift_clock_pin_out); endproperty
  a_fall_out: assert property (p_fall_out) else $error("data out moved off falling edge");
  property p_vector; rd_irq |-> prdata[31:16] == sync_serial_pkg::irq_vector; endproperty
  a_vector: assert property (p_vector) else $error("vector field wrong");
  property p_level; rd_irq |-> xfer_irq_level == prdata[3:2]; endproperty
  a_level: assert property (p_level) else $error("priority output wrong");
  property p_gate; rd_irq && !prdata[1] |-> !xfer_irq; endproperty
  a_gate: assert property (p_gate) else $error("request passed while disabled");
endmodule

// ==== dv/serial_partner.sv ====
// far-side serial device model, lsb first, clocks frames in slave mode
`timescale 1ns/1ps
module serial_partner (
  input wire logic pclk, // pacing clock
  input wire logic sck, // resolved clock pin
  input wire logic sout, // data from the port
  output logic sdi, // data to the port
  output logic sck_drv // clock drive, high at rest
);
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  logic [3:0] n = 4'h0;
  logic [3:0] idle = 4'h0;
  initial sdi = 1'b0;
  initial sck_drv = 1'b1;
  // load a byte and restart the frame
  task automatic arm(input logic [7:0] b);
    tx = b;
    n = 4'h0;
  endtask
  // k clock pulses of half period h cycles
  task automatic pulses(input int k, input int h);
    repeat (k) begin
      @(posedge pclk) sck_drv <= 1'b0;
      repeat (h) @(posedge pclk);
      sck_drv <= 1'b1;
      repeat (h) @(posedge pclk);
    end
  endtask
  // new bit on falling edges
  always @(negedge sck) sdi <= (n < 4'd8) ? tx[n[2:0]] : ~sdi;
  // capture on rising edges, eight per frame
  always @(posedge sck) begin
    if (n < 4'd8) begin
      rx <= {sout, rx[7:1]};
      n <= n + 4'd1;
    end
  end
  // data line released a while after the frame: toggles
  always @(posedge pclk) begin
    idle <= (n == 4'd8 && sck && idle < 4'd9) ? idle + 4'd1 : (n == 4'd8 ? idle : 4'd0);
    if (idle == 4'd9) sdi <= ~sdi;
  end
endmodule

// ==== dv/tb_sync_serial_port.sv ====
// self-checking bench for the synchronous serial port
`timescale 1ns/1ps
module tb_sync_serial_port;
  localparam logic [11:0] ctl = sync_serial_pkg::addr_serial_control;
  localparam logic [11:0] dat = sync_serial_pkg::addr_serial_shift_data;
  localparam logic [11:0] irqa = sync_serial_pkg::addr_xfer_irq;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, tbc = 0, fis = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, sck_out, sck_oe, sdi, sout, irq, e, sck_part;
  logic [1:0] lvl, cyc = 2'b00;
  wire logic sck_pin;
  int err_count = 0;
  int checks_done = 0;
  int k;
  assign sck_pin = sck_oe ? sck_out : sck_part;
  always #12.5 pclk = ~pclk;
  // time-base ticks and instruction strobes
  always @(posedge pclk) begin
    cyc <= cyc + 2'b01;
    tbc <= cyc[1];
    fis <= cyc[0];
  end
  sync_serial_port DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .time_base_clock(tbc), .first_instr_state(fis), .shift_clock_pin_in(sck_pin),
    .shift_clock_pin_out(sck_out), .shift_clock_pin_oe(sck_oe), .serial_in_pin(sdi),
    .serial_out_pin(sout), .xfer_irq(irq), .xfer_irq_level(lvl));
  serial_partner far (.pclk, .sck(sck_pin), .sout, .sdi, .sck_drv(sck_part));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, result left in q and e
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one byte each way with mode bits m already written
  task automatic xfer(input logic [7:0] d, input logic [7:0] t, input logic [31:0] m);
    far.arm(t);
    apb(1'b1, dat, {24'h0, d});
    apb(1'b0, ctl, 32'h0);
    cmp(q & 32'hffffff8f, 32'h88 | m);
    if (m[2]) far.pulses(9, 6);
    k = 0;
    do begin
      apb(1'b0, ctl, 32'h0);
      k++;
    end while (q[3] === 1'b1 && k < 3000);
    cmp(q, 32'h80 | m);
    apb(1'b0, dat, 32'h0);
    cmp(q, {24'h0, t});
    cmp({24'h0, far.rx}, {24'h0, d});
    cmp({31'h0, sout}, {31'h0, d[7]});
  endtask
  task automatic close_out;
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (80000) @(posedge pclk);
    err_count++;
    close_out;
  end
  // main sequence
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ctl, 32'h0);
    cmp(q, 32'h80);
    apb(1'b1, ctl, 32'hf8);
    apb(1'b0, ctl, 32'h0);
    cmp(q, 32'h80);
    apb(1'b1, irqa, 32'h0a);
    apb(1'b0, irqa, 32'h0);
    cmp(q, 32'h003e000a);
    apb(1'b1, sync_serial_pkg::addr_baud_timer, 32'h1fe);
    apb(1'b0, 12'h010, 32'h0);
    cmp({31'h0, e}, 32'h1);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, ctl, s);
      xfer(8'h3c + s[7:0], 8'ha5 ^ s[7:0], s);
      repeat (4) @(posedge pclk);
      cmp({31'h0, irq}, 32'h1);
      cmp({30'h0, lvl}, 32'h2);
      apb(1'b1, irqa, 32'h0a);
      repeat (3) @(posedge pclk);
      cmp({31'h0, irq}, 32'h0);
    end
    apb(1'b1, ctl, 32'h2);
    far.arm(8'h00);
    apb(1'b1, dat, 32'h11);
    @(posedge sck_pin);
    repeat (10) @(posedge pclk);
    apb(1'b0, ctl, 32'h0);
    cmp(q, 32'h9a);
    xfer(8'hc3, 8'h5a, 32'h2);
    apb(1'b1, irqa, 32'h08);
    apb(1'b1, ctl, 32'h7);
    xfer(8'h96, 8'h4b, 32'h7);
    apb(1'b0, irqa, 32'h0);
    cmp(q, 32'h003e0009);
    close_out;
  end
endmodule
bind sync_serial_port sync_serial_port_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .time_base_clock, .first_instr_state, .shift_clock_pin_in,
  .shift_clock_pin_out, .shift_clock_pin_oe, .serial_in_pin, .serial_out_pin, .xfer_irq, .xfer_irq_level);
